/* File: logic/hvpp_pkg.sv */
// hvpp_pkg: constants for the parallel high-voltage programming port
// assumes: one 40 MHz clock, all programmer pins synchronised inside the port
package hvpp_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned ENTRY_HOLD_NS   = 10000;
  localparam int unsigned ENTRY_HOLD_CYC  = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLASH_PROG_CYC  = 64;
  localparam int unsigned EE_PROG_CYC     = 32;
  localparam int unsigned FUSE_PROG_CYC   = 16;
  localparam int unsigned ERASE_CYC       = 256;
  localparam int unsigned BUSY_CNT_W      = 16;

  // geometry
  localparam int unsigned FL_WORD_BITS    = 5;
  localparam int unsigned FL_PAGE_BITS    = 6;
  localparam int unsigned FL_ADDR_W       = FL_WORD_BITS + FL_PAGE_BITS;
  localparam int unsigned FL_PAGE_WORDS   = 32;
  localparam int unsigned FL_WORDS        = 2048;
  localparam int unsigned EE_BYTE_BITS    = 2;
  localparam int unsigned EE_ADDR_W       = 8;
  localparam int unsigned EE_PAGE_BYTES   = 4;
  localparam int unsigned EE_BYTES        = 256;

  // action select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  // reset values
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] FUSE_LO_RST  = 8'h62;
  localparam logic [7:0] FUSE_HI_RST  = 8'hDF;
  localparam logic [7:0] FUSE_EX_RST  = 8'hFF;
  localparam logic [7:0] LOCK_RST     = 8'hFF;
  localparam int unsigned KEEP_EE_BIT = 3;
  // arbitrary neutral identity bytes
  localparam logic [7:0] SIG_BYTE0    = 8'h5A;
  localparam logic [7:0] SIG_BYTE1    = 8'h01;
  localparam logic [7:0] SIG_BYTE2    = 8'h02;
  localparam logic [7:0] CAL_BYTE     = 8'h80;

  typedef enum logic [1:0] {
    HV_IDLE  = 2'b00,
    HV_BUSY  = 2'b01,
    HV_CLEAR = 2'b11
  } hvpp_state_e;

endpackage : hvpp_pkg

/* File: logic/hvpp_sync.sv */
// hvpp_sync: two-flop synchroniser for a group of pin levels
// assumes: inputs asynchronous to clk_i
module hvpp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else if (en_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : hvpp_sync

/* File: logic/hvpp_edge.sv */
// hvpp_edge: edge detector on a synchronised level
// assumes: input already synchronised to clk_i
module hvpp_edge (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic lvl_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else if (en_i) begin
      prev_q <= lvl_i;
    end
  end

  assign rise_o = en_i & lvl_i & ~prev_q;
  assign fall_o = en_i & ~lvl_i & prev_q;
endmodule : hvpp_edge

/* File: logic/hvpp_port.sv */
// hvpp_port: parallel high-voltage programming port with flash and eeprom
// storage modelled as arrays, fuses and lock as registers
// assumes: programmer pins are asynchronous; hv_present_i is the entry level
module hvpp_port
  import hvpp_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic       CLK_EN_I,
  // mode entry
  input  wire logic       HV_PRESENT_I,
  output logic            PROG_MODE_O,
  // strobes and selects
  input  wire logic       LOAD_STROBE_I,
  input  wire logic       PAGE_LATCH_STROBE_I,
  input  wire logic       WRITE_N_I,
  input  wire logic       READ_N_I,
  input  wire logic       ACTION_SEL_BIT0_I,
  input  wire logic       ACTION_SEL_BIT1_I,
  input  wire logic       BYTE_SEL_A_I,
  input  wire logic       BYTE_SEL_B_I,
  // data bus
  input  wire logic [7:0] DATA_I,
  output logic      [7:0] DATA_O,
  output logic            DATA_OE_O,
  // status
  output logic            READY_NOT_BUSY_O
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int unsigned NSYNC = 17;
  logic [NSYNC-1:0] pins_s;
  logic hv_s, ld_s, pl_s, wr_s, rd_s, act0_s, act1_s, bsa_s, bsb_s;
  logic [7:0] data_s;

  hvpp_sync #(.W(NSYNC)) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .en_i    (CLK_EN_I),
    .d_i     ({HV_PRESENT_I, LOAD_STROBE_I, PAGE_LATCH_STROBE_I, ~WRITE_N_I,
               ~READ_N_I, ACTION_SEL_BIT0_I, ACTION_SEL_BIT1_I, BYTE_SEL_A_I,
               BYTE_SEL_B_I, DATA_I}),
    .q_o     (pins_s)
  );

  // write and read strobes synchronised inverted so reset reads as inactive
  assign {hv_s, ld_s, pl_s, wr_s, rd_s, act0_s, act1_s, bsa_s, bsb_s} =
         pins_s[16:8];
  assign data_s = pins_s[7:0];

  logic ld_rise, pl_rise, wr_fall;

  hvpp_edge u_ld (
    .clk_i(CLK_I), .rst_n_i(RESET_N_I), .en_i(CLK_EN_I),
    .lvl_i(ld_s), .rise_o(ld_rise), .fall_o()
  );
  hvpp_edge u_pl (
    .clk_i(CLK_I), .rst_n_i(RESET_N_I), .en_i(CLK_EN_I),
    .lvl_i(pl_s), .rise_o(pl_rise), .fall_o()
  );
  // wr_s holds the active level, so its rise is the falling write pin
  hvpp_edge u_wr (
    .clk_i(CLK_I), .rst_n_i(RESET_N_I), .en_i(CLK_EN_I),
    .lvl_i(wr_s), .rise_o(wr_fall), .fall_o()
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode entry: pattern held low for the hold time after high voltage
  logic [BUSY_CNT_W-1:0] entry_cnt_q;
  logic                  mode_q;
  logic                  pattern_ok;
  assign pattern_ok = ~pl_s & ~act1_s & ~act0_s & ~bsa_s;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      entry_cnt_q <= '0;
      mode_q      <= 1'b0;
    end else if (CLK_EN_I) begin
      if (!hv_s) begin
        entry_cnt_q <= '0;
        mode_q      <= 1'b0;
      end else if (!mode_q) begin
        if (!pattern_ok) begin
          entry_cnt_q <= '0;
        end else if (entry_cnt_q == BUSY_CNT_W'(ENTRY_HOLD_CYC - 1)) begin
          mode_q <= 1'b1;
        end else begin
          entry_cnt_q <= entry_cnt_q + 1'b1;
        end
      end
    end
  end
  assign PROG_MODE_O = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // command, address and data loading
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dat_lo_q, dat_hi_q;
  logic       load_ok;
  assign load_ok = mode_q & ld_rise;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cmd_q     <= CMD_NOP;
      addr_lo_q <= '0;
      addr_hi_q <= '0;
      dat_lo_q  <= '0;
      dat_hi_q  <= '0;
    end else if (CLK_EN_I) begin
      if (!mode_q) begin
        cmd_q <= CMD_NOP;
      end else if (load_ok) begin
        case ({act1_s, act0_s})
          ACT_ADDR: begin
            if (bsa_s) addr_hi_q <= data_s;
            else       addr_lo_q <= data_s;
          end
          ACT_DATA: begin
            if (bsa_s) dat_hi_q <= data_s;
            else       dat_lo_q <= data_s;
          end
          ACT_CMD:  cmd_q <= data_s;
          default:  ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage arrays and page buffers
  logic [15:0] flash_mem [FL_WORDS];
  logic [7:0]  ee_mem    [EE_BYTES];
  logic [15:0] fl_buf_q  [FL_PAGE_WORDS];
  logic [7:0]  ee_buf_q  [EE_PAGE_BYTES];
  logic [FL_PAGE_WORDS-1:0] fl_dirty_q;
  logic [EE_PAGE_BYTES-1:0] ee_dirty_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ex_q, lock_q;

  logic [FL_ADDR_W-1:0] fl_addr;
  logic [EE_ADDR_W-1:0] ee_addr;
  assign fl_addr = {addr_hi_q[FL_ADDR_W-9:0], addr_lo_q};
  assign ee_addr = addr_lo_q;

  logic [FL_WORD_BITS-1:0] fl_word;
  logic [FL_PAGE_BITS-1:0] fl_page;
  logic [EE_BYTE_BITS-1:0] ee_byte;
  assign fl_word = fl_addr[FL_WORD_BITS-1:0];
  assign fl_page = fl_addr[FL_ADDR_W-1:FL_WORD_BITS];
  assign ee_byte = ee_addr[EE_BYTE_BITS-1:0];

  logic prog_done;

  // page latch fills the buffer selected by the command
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fl_dirty_q <= '0;
      ee_dirty_q <= '0;
    end else if (CLK_EN_I) begin
      if (prog_done || !mode_q) begin
        fl_dirty_q <= '0;
        ee_dirty_q <= '0;
      end
      // a latch in the commit cycle belongs to the next page, so it wins
      if (mode_q && pl_rise) begin
        if (cmd_q == CMD_WR_FLASH) fl_dirty_q[fl_word] <= 1'b1;
        if (cmd_q == CMD_WR_EE)    ee_dirty_q[ee_byte] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (CLK_EN_I && mode_q && pl_rise) begin
      if (cmd_q == CMD_WR_FLASH) fl_buf_q[fl_word] <= {dat_hi_q, dat_lo_q};
      if (cmd_q == CMD_WR_EE)    ee_buf_q[ee_byte] <= dat_lo_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer
  hvpp_state_e            state_q;
  logic [BUSY_CNT_W-1:0]  busy_cnt_q;
  logic [7:0]             op_cmd_q;
  logic                   op_bsa_q, op_bsb_q;
  logic                   erase_locks;

  // busy time chosen per command
  function automatic logic [BUSY_CNT_W-1:0] busy_len(input logic [7:0] c);
    case (c)
      CMD_ERASE:    busy_len = BUSY_CNT_W'(ERASE_CYC);
      CMD_WR_FLASH: busy_len = BUSY_CNT_W'(FLASH_PROG_CYC);
      CMD_WR_EE:    busy_len = BUSY_CNT_W'(EE_PROG_CYC);
      CMD_WR_FUSE,
      CMD_WR_LOCK:  busy_len = BUSY_CNT_W'(FUSE_PROG_CYC);
      default:      busy_len = '0;
    endcase
  endfunction : busy_len

  assign prog_done   = (state_q == HV_BUSY) && (busy_cnt_q == '0);
  assign erase_locks = (state_q == HV_CLEAR);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q    <= HV_IDLE;
      busy_cnt_q <= '0;
      op_cmd_q   <= CMD_NOP;
      op_bsa_q   <= 1'b0;
      op_bsb_q   <= 1'b0;
    end else if (CLK_EN_I) begin
      case (state_q)
        HV_IDLE: begin
          if (mode_q && wr_fall && busy_len(cmd_q) != '0) begin
            state_q    <= HV_BUSY;
            busy_cnt_q <= busy_len(cmd_q) - 1'b1;
            op_cmd_q   <= cmd_q;
            op_bsa_q   <= bsa_s;
            op_bsb_q   <= bsb_s;
          end
        end
        HV_BUSY: begin
          if (busy_cnt_q != '0) begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
          end else if (op_cmd_q == CMD_ERASE) begin
            state_q <= HV_CLEAR;
          end else begin
            state_q <= HV_IDLE;
          end
        end
        HV_CLEAR: state_q <= HV_IDLE;
        default:  state_q <= HV_IDLE;
      endcase
    end
  end

  // memory commit at end of busy time
  always_ff @(posedge CLK_I) begin
    if (CLK_EN_I && prog_done) begin
      case (op_cmd_q)
        CMD_WR_FLASH: begin
          for (int i = 0; i < FL_PAGE_WORDS; i++) begin
            if (fl_dirty_q[i])
              flash_mem[{fl_page, FL_WORD_BITS'(i)}] <= fl_buf_q[i];
          end
        end
        CMD_WR_EE: begin
          for (int i = 0; i < EE_PAGE_BYTES; i++) begin
            if (ee_dirty_q[i])
              ee_mem[{ee_addr[EE_ADDR_W-1:EE_BYTE_BITS], EE_BYTE_BITS'(i)}] <= ee_buf_q[i];
          end
        end
        CMD_ERASE: begin
          for (int i = 0; i < FL_WORDS; i++) flash_mem[i] <= {2{ERASED_BYTE}};
          if (fuse_hi_q[KEEP_EE_BIT]) begin
            for (int i = 0; i < EE_BYTES; i++) ee_mem[i] <= ERASED_BYTE;
          end
        end
        default: ;
      endcase
    end
  end

  // fuses survive erase; locks clear one cycle after the flash is erased
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fuse_lo_q <= FUSE_LO_RST;
      fuse_hi_q <= FUSE_HI_RST;
      fuse_ex_q <= FUSE_EX_RST;
      lock_q    <= LOCK_RST;
    end else if (CLK_EN_I) begin
      if (erase_locks) begin
        lock_q <= LOCK_RST;
      end else if (prog_done && op_cmd_q == CMD_WR_FUSE) begin
        case ({op_bsb_q, op_bsa_q})
          2'b00:   fuse_lo_q <= dat_lo_q;
          2'b01:   fuse_hi_q <= dat_lo_q;
          2'b10:   fuse_ex_q <= dat_lo_q;
          default: ;
        endcase
      end else if (prog_done && op_cmd_q == CMD_WR_LOCK) begin
        lock_q <= lock_q & dat_lo_q; // only program, never erase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and status outputs
  logic [7:0] rd_d;
  logic [15:0] fl_word_rd;
  assign fl_word_rd = flash_mem[fl_addr];

  always_comb begin
    rd_d = '0;
    case (cmd_q)
      CMD_RD_FLASH: rd_d = bsa_s ? fl_word_rd[15:8] : fl_word_rd[7:0];
      CMD_RD_EE:    rd_d = ee_mem[ee_addr];
      CMD_RD_FUSE: begin
        case ({bsb_s, bsa_s})
          2'b00:   rd_d = fuse_lo_q;
          2'b11:   rd_d = fuse_hi_q;
          2'b10:   rd_d = fuse_ex_q;
          default: rd_d = lock_q;
        endcase
      end
      CMD_RD_SIG: begin
        case (addr_lo_q)
          8'h00:   rd_d = SIG_BYTE0;
          8'h01:   rd_d = CAL_BYTE;
          8'h02:   rd_d = SIG_BYTE1;
          8'h04:   rd_d = SIG_BYTE2;
          default: rd_d = ERASED_BYTE;
        endcase
      end
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      DATA_O           <= '0;
      DATA_OE_O        <= 1'b0;
      READY_NOT_BUSY_O <= 1'b1;
    end else if (CLK_EN_I) begin
      DATA_OE_O        <= mode_q & rd_s;
      DATA_O           <= rd_d;
      READY_NOT_BUSY_O <= (state_q == HV_IDLE) &&
                          !(mode_q && wr_fall && busy_len(cmd_q) != '0);
    end
  end

endmodule : hvpp_port

/* File: verification/hvpp_port_sva.sv */
// hvpp_port_sva: pin-level timing checks for hvpp_port
// assumes: CLK_EN_I tied high, so each pin acts three clocks late
module hvpp_port_sva (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // pins watched
  input wire logic HV_PRESENT_I,
  input wire logic PAGE_LATCH_STROBE_I,
  input wire logic WRITE_N_I,
  input wire logic READ_N_I,
  input wire logic ACTION_SEL_BIT0_I,
  input wire logic ACTION_SEL_BIT1_I,
  input wire logic BYTE_SEL_A_I,
  // outputs watched
  input wire logic PROG_MODE_O,
  input wire logic DATA_OE_O,
  input wire logic READY_NOT_BUSY_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic [7:0]  wr_age_q;
  logic [15:0] hv_cnt_q;
  logic        entry_pins;
  assign entry_pins = HV_PRESENT_I && !(PAGE_LATCH_STROBE_I || ACTION_SEL_BIT1_I
                                       || ACTION_SEL_BIT0_I || BYTE_SEL_A_I);
  ////////////////////////////////////////////////////////////////////////////////
  // clocks since the write strobe fell, saturating so old strobes never match
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) wr_age_q <= 8'hFF;
    else if ($fell(WRITE_N_I)) wr_age_q <= 8'h00;
    else if (wr_age_q != 8'hFF) wr_age_q <= wr_age_q + 8'h01;
  end
  // clocks the entry pattern has stood with high voltage present
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) hv_cnt_q <= 16'h0000;
    else if (!entry_pins) hv_cnt_q <= 16'h0000;
    else if (hv_cnt_q != 16'hFFFF) hv_cnt_q <= hv_cnt_q + 16'h0001;
  end
  sequence s_busy_run;
    !READY_NOT_BUSY_O [*8] ##[1:300] READY_NOT_BUSY_O;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) !RESET_N_I |->
    !PROG_MODE_O && !DATA_OE_O && READY_NOT_BUSY_O) else $error("port active in reset");
  a_oe_needs_read: assert property (DATA_OE_O |-> !$past(READ_N_I, 3))
    else $error("bus driven without read strobe");
  a_bus_released: assert property (READ_N_I [*4] |-> !DATA_OE_O)
    else $error("bus still driven after read ended");
  a_busy_cause: assert property ($fell(READY_NOT_BUSY_O) |->
    wr_age_q inside {[8'h01:8'h06]}) else $error("busy without write strobe");
  a_busy_bounded: assert property ($fell(READY_NOT_BUSY_O) |-> s_busy_run)
    else $error("busy too short or too long");
  a_mode_exit: assert property (!HV_PRESENT_I [*4] |-> !PROG_MODE_O)
    else $error("mode kept without high voltage");
  a_entry_hold: assert property ($rose(PROG_MODE_O) |-> hv_cnt_q >= 16'h0190)
    else $error("mode entered before pattern held");
  a_entry_time: assert property (hv_cnt_q == 16'h01A4 |-> PROG_MODE_O)
    else $error("mode not entered after pattern held");
endmodule : hvpp_port_sva

bind hvpp_port hvpp_port_sva hvpp_port_sva_i (.CLK_I, .RESET_N_I, .HV_PRESENT_I,
  .PAGE_LATCH_STROBE_I, .WRITE_N_I, .READ_N_I, .ACTION_SEL_BIT0_I, .ACTION_SEL_BIT1_I,
  .BYTE_SEL_A_I, .PROG_MODE_O, .DATA_OE_O, .READY_NOT_BUSY_O);

/* File: verification/hvpp_pm.sv */
// hvpp_pm: model of the parallel programmer driving the port pins
// assumes: the bench calls its tasks; pins move at falling clock edges
module hvpp_pm (
  // clock
  input  wire logic       clk_i,
  // pins toward the port
  output logic            hv_o,
  output logic            load_o,
  output logic            page_latch_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic [1:0]      xa_o,
  output logic            bsa_o,
  output logic            bsb_o,
  output logic [7:0]      d_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {hv_o, load_o, page_latch_o, xa_o, bsa_o, bsb_o, d_o} = '0;
    {wr_n_o, rd_n_o} = 2'h3;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold
  // ten-clock strobes; load has four clocks of setup and hold, page latch one and four, write four and two
  task automatic ld(input logic [1:0] xa, input logic a, input logic [7:0] d);
    @(negedge clk_i);
    {xa_o, bsa_o, bsb_o, d_o} = {xa, a, 1'b0, d};
    hold(4);
    load_o = 1'b1;
    hold(10);
    load_o = 1'b0;
    hold(4);
  endtask : ld
  task automatic pl();
    hold(1);
    page_latch_o = 1'b1;
    hold(10);
    page_latch_o = 1'b0;
    hold(4);
  endtask : pl
  task automatic wr(input logic b, input logic a);
    @(negedge clk_i);
    {bsb_o, bsa_o} = {b, a};
    hold(4);
    wr_n_o = 1'b0;
    hold(10);
    wr_n_o = 1'b1;
    hold(2);
  endtask : wr
  // released bus floats: show the inverse of the last value
  task automatic rd_on(input logic b, input logic a);
    @(negedge clk_i);
    {bsb_o, bsa_o, rd_n_o} = {b, a, 1'b0};
    d_o = ~d_o;
  endtask : rd_on
  task automatic rd_off();
    @(negedge clk_i);
    rd_n_o = 1'b1;
    hold(4);
  endtask : rd_off
  task automatic enter();
    @(negedge clk_i);
    {page_latch_o, xa_o, bsa_o} = '0;
    hv_o = 1'b1;
    hold(12000);
  endtask : enter
  task automatic leave();
    @(negedge clk_i);
    hv_o = 1'b0;
    hold(6);
  endtask : leave
endmodule : hvpp_pm

/* File: verification/hvpp_port_test.sv */
// hvpp_port_test: self-checking bench for the programming port
// assumes: hvpp_pm drives every pin, clock enable stays high
module hvpp_port_test
  import hvpp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  // pulled low at 1 ns so the asynchronous reset sees a real falling edge
  logic       rst_n = 1'b1;
  logic       chk_q = 1'b0;
  logic       hv, lds, pls, wr_n, rd_n, bsa, bsb, mode, oe, rdy;
  logic [1:0] xa;
  logic [7:0] pd, dq, d_in, hi_f;
  logic [7:0] w[4], fa[3], ex[6], fz[4];
  logic [7:0] exp_q[$];
  int         n_errors = 0;
  int         comparisons = 0;
  always #12.5 clk = ~clk;
  assign d_in = oe ? dq : pd;
  hvpp_pm hvpp_pm_i (.clk_i(clk), .hv_o(hv), .load_o(lds), .page_latch_o(pls), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .xa_o(xa), .bsa_o(bsa), .bsb_o(bsb), .d_o(pd));
  hvpp_port hvpp_port_i (.CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1), .HV_PRESENT_I(hv),
    .PROG_MODE_O(mode), .LOAD_STROBE_I(lds), .PAGE_LATCH_STROBE_I(pls), .WRITE_N_I(wr_n),
    .READ_N_I(rd_n), .ACTION_SEL_BIT0_I(xa[0]), .ACTION_SEL_BIT1_I(xa[1]),
    .BYTE_SEL_A_I(bsa), .BYTE_SEL_B_I(bsb), .DATA_I(d_in), .DATA_O(dq),
    .DATA_OE_O(oe), .READY_NOT_BUSY_O(rdy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic fail(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task automatic flag(input logic got, input logic want, input string m);
    comparisons++;
    if (got !== want) fail(m);
  endtask : flag
  task automatic rd(input logic b, input logic a, input logic [7:0] e);
    hvpp_pm_i.rd_on(b, a);
    hvpp_pm_i.hold(8);
    exp_q.push_back(e);
    chk_q = 1'b1;
    hvpp_pm_i.hold(1);
    chk_q = 1'b0;
    hvpp_pm_i.rd_off();
  endtask : rd
  // write strobe, then a bounded wait for ready
  task automatic prog(input logic b, input logic a);
    int i;
    hvpp_pm_i.wr(b, a);
    flag(rdy, 1'b0, "no busy after write strobe");
    for (i = 0; i < 400 && rdy !== 1'b1; i++) hvpp_pm_i.hold(1);
    if (rdy !== 1'b1) begin
      fail("busy never ended");
      finish_test();
    end
  endtask : prog
  always @(posedge clk) begin
    if (chk_q === 1'b1) begin
      comparisons++;
      if ({oe, dq} !== {1'b1, exp_q.pop_front()}) fail("read data mismatch");
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1 rst_n = 1'b0;
    void'($urandom(48898));
    foreach (w[i]) w[i] = 8'($urandom % 255);
    fa = '{8'h1F, 8'h00, 8'h20};
    ex = '{w[0], w[1], w[2], w[3], ERASED_BYTE, ERASED_BYTE};
    hi_f = FUSE_HI_RST & ~(8'h01 << KEEP_EE_BIT);
    fz = '{FUSE_LO_RST, 8'hFC, FUSE_EX_RST, hi_f};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    flag(mode | ~rdy | oe, 1'b0, "outputs not idle after reset");
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_ERASE);
    hvpp_pm_i.wr(1'b0, 1'b0);
    flag(rdy, 1'b1, "busy outside programming mode");
    hvpp_pm_i.enter();
    flag(mode, 1'b1, "mode not entered");
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_ERASE);
    prog(1'b0, 1'b0);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
    hvpp_pm_i.ld(ACT_ADDR, 1'b1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      hvpp_pm_i.ld(ACT_ADDR, 1'b0, fa[k]);
      hvpp_pm_i.ld(ACT_DATA, 1'b0, w[2*k]);
      hvpp_pm_i.ld(ACT_DATA, 1'b1, w[2*k+1]);
      hvpp_pm_i.pl();
    end
    prog(1'b0, 1'b0);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
    for (int k = 0; k < 3; k++) begin
      hvpp_pm_i.ld(ACT_ADDR, 1'b0, fa[k]);
      rd(1'b0, 1'b0, ex[2*k]);
      rd(1'b0, 1'b1, ex[2*k+1]);
    end
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_WR_EE);
    hvpp_pm_i.ld(ACT_ADDR, 1'b0, 8'h07);
    hvpp_pm_i.ld(ACT_DATA, 1'b0, w[1]);
    hvpp_pm_i.pl();
    prog(1'b0, 1'b0);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_EE);
    rd(1'b0, 1'b0, w[1]);
    hvpp_pm_i.ld(ACT_ADDR, 1'b0, 8'h08);
    rd(1'b0, 1'b0, ERASED_BYTE);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
    hvpp_pm_i.ld(ACT_DATA, 1'b0, 8'hFC);
    prog(1'b0, 1'b0);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
    hvpp_pm_i.ld(ACT_DATA, 1'b0, hi_f);
    prog(1'b0, 1'b1);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
    foreach (fz[k]) rd(1'(k >> 1), 1'(k), fz[k]);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_SIG);
    hvpp_pm_i.ld(ACT_ADDR, 1'b0, 8'h00);
    rd(1'b0, 1'b0, SIG_BYTE0);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_ERASE);
    prog(1'b0, 1'b0);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd(1'b0, 1'b1, LOCK_RST);
    rd(1'b1, 1'b1, hi_f);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_EE);
    hvpp_pm_i.ld(ACT_ADDR, 1'b0, 8'h07);
    rd(1'b0, 1'b0, w[1]);
    hvpp_pm_i.ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
    hvpp_pm_i.ld(ACT_ADDR, 1'b0, 8'h1F);
    hvpp_pm_i.ld(ACT_IDLE, 1'b0, CMD_ERASE);
    rd(1'b0, 1'b0, ERASED_BYTE);
    hvpp_pm_i.leave();
    flag(mode, 1'b0, "mode kept after exit");
    finish_test();
  end
endmodule : hvpp_port_test
